// file: hw/orcc_pkg.sv
package orcc_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_MAINT_CTRL = 8'h44;
    localparam logic [7:0] IDX_REMOTE_CMD_CTRL = 8'h4a;
    localparam logic [7:0] IDX_REMOTE_CMD_ADDRESS_BYTE = 8'h4b;
    localparam logic [7:0] IDX_REMOTE_CMD_DATA_BYTE = 8'h4c;
    localparam logic [7:0] IDX_MAINT_TX_PACKET_COUNT = 8'h4d;
    localparam logic [7:0] IDX_MAINT_RX_PACKET_COUNT = 8'h4e;
    localparam logic [7:0] IDX_PARTNER_STATUS_SHADOW = 8'h4f;
    localparam logic [7:0] IDX_MODEL_INFO_2 = 8'h56;
    localparam logic [7:0] IDX_MODEL_INFO_3 = 8'h57;
    localparam logic [7:0] IDX_CONVERTER_CFG = 8'h60;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE_ZERO = 8'h00;
    localparam logic [7:0] RST_REMOTE_CMD_CTRL = 8'h22;
    localparam logic [7:0] RST_SHADOW_TERMINAL = 8'h07;
    localparam logic [7:0] RST_SHADOW_CENTER = 8'h47;
    localparam logic [7:0] RST_CONVERTER_CFG = 8'h00;

    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    // remote command control: operating mode in [1:0], capability in [5:4]
    localparam int CMD_MODE_LSB = 0;
    localparam int CMD_CAP_LSB = 4;
    localparam logic [7:0] CMD_CTRL_RW_MASK = 8'hcf;
    localparam logic [1:0] OPMODE_NORMAL = 2'b00;
    localparam logic [1:0] OPMODE_EXTENDED = 2'b10;
    // converter config: bit 0 set selects central office converter mode
    localparam int CFG_CENTRAL_BIT = 0;
    // shared status layout: bit 6 reports the link option
    localparam int STATUS_LINK_OPTION_BIT = 6;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_ONE = 8'h01;

endpackage

// file: hw/orcc_regs.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none

module orcc_regs (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [orcc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [orcc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [orcc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [orcc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // optical link state
    input wire logic optical_link_up,
    input wire logic [7:0] partner_status,
    input wire logic warm_reset,
    input wire logic chip_power_down,
    // maintenance frame events
    input wire logic maint_tx_sent,
    input wire logic maint_rx_done,
    input wire logic rx_crc_ok,
    input wire logic rx_opcode_ok,
    input wire logic rx_direction_ok,
    // frame assembly
    input wire logic remote_cmd_issue,
    output logic [7:0] frame_field_byte4,
    output logic [7:0] frame_field_byte5
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // true when a byte address selects the word of a register index
    function automatic logic reg_hit(input logic [orcc_pkg::ADDR_W-1:0] addr,
                                     input logic [7:0] idx);
        reg_hit = (addr == {2'b00, idx, 2'b00});
    endfunction

    // saturating increment of a packet counter
    function automatic logic [7:0] sat_inc(input logic [7:0] count);
        if (count == orcc_pkg::COUNT_MAX) begin
            sat_inc = orcc_pkg::COUNT_MAX;
        end else begin
            sat_inc = count + orcc_pkg::COUNT_ONE;
        end
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] maint_ctrl;
    logic [7:0] remote_cmd_ctrl;
    logic [7:0] remote_cmd_address_byte;
    logic [7:0] remote_cmd_data_byte;
    logic [7:0] maint_tx_packet_count;
    logic [7:0] maint_rx_packet_count;
    logic [7:0] partner_status_shadow;
    logic [7:0] model_info_2;
    logic [7:0] model_info_3;
    logic [7:0] converter_cfg;

    // bus holding state
    logic aw_full;
    logic w_full;
    logic [orcc_pkg::ADDR_W-1:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane0;

    // decoded controls
    logic central_mode;
    logic extended_mode;
    logic do_write;
    logic wr_lane_ok;
    logic clear_counts;
    logic rx_valid_packet;
    logic use_remote_cmd;
    logic shadow_hold;
    logic rd_hit;
    logic [7:0] rd_byte;

    assign central_mode = converter_cfg[orcc_pkg::CFG_CENTRAL_BIT];
    assign extended_mode = (remote_cmd_ctrl[orcc_pkg::CMD_MODE_LSB +: 2]
                            == orcc_pkg::OPMODE_EXTENDED);

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------

    // address and data are taken independently, one transfer at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
        end else if (s_axi_awready) begin
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && !aw_full && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
        end else if (s_axi_wready) begin
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && !w_full && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // latched write address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            wr_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full <= 1'b0;
        end
    end

    // latched write data, low byte only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full <= 1'b0;
            wr_byte <= orcc_pkg::RST_BYTE_ZERO;
            wr_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            wr_byte <= s_axi_wdata[7:0];
            wr_lane0 <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_full <= 1'b0;
        end
    end

    assign do_write = aw_full && w_full && !s_axi_bvalid;
    assign wr_lane_ok = do_write && wr_lane0;

    // response once both halves are in; unmapped words answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= orcc_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known(wr_addr) ? orcc_pkg::RESP_OKAY : orcc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // any mapped word, writable or not
    function automatic logic wr_known(input logic [orcc_pkg::ADDR_W-1:0] addr);
        wr_known = reg_hit(addr, orcc_pkg::IDX_MAINT_CTRL)
                || reg_hit(addr, orcc_pkg::IDX_REMOTE_CMD_CTRL)
                || reg_hit(addr, orcc_pkg::IDX_REMOTE_CMD_ADDRESS_BYTE)
                || reg_hit(addr, orcc_pkg::IDX_REMOTE_CMD_DATA_BYTE)
                || reg_hit(addr, orcc_pkg::IDX_MAINT_TX_PACKET_COUNT)
                || reg_hit(addr, orcc_pkg::IDX_MAINT_RX_PACKET_COUNT)
                || reg_hit(addr, orcc_pkg::IDX_PARTNER_STATUS_SHADOW)
                || reg_hit(addr, orcc_pkg::IDX_MODEL_INFO_2)
                || reg_hit(addr, orcc_pkg::IDX_MODEL_INFO_3)
                || reg_hit(addr, orcc_pkg::IDX_CONVERTER_CFG);
    endfunction

    // ------------------------------------------------------------
    // software writable registers
    // ------------------------------------------------------------

    // maintenance control and converter configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            maint_ctrl <= orcc_pkg::RST_BYTE_ZERO;
            converter_cfg <= orcc_pkg::RST_CONVERTER_CFG;
        end else if (wr_lane_ok) begin
            if (reg_hit(wr_addr, orcc_pkg::IDX_MAINT_CTRL)) begin
                maint_ctrl <= wr_byte;
            end
            if (reg_hit(wr_addr, orcc_pkg::IDX_CONVERTER_CFG)) begin
                converter_cfg <= wr_byte;
            end
        end
    end

    // remote command control keeps its read-only capability bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remote_cmd_ctrl <= orcc_pkg::RST_REMOTE_CMD_CTRL;
        end else if (wr_lane_ok && reg_hit(wr_addr, orcc_pkg::IDX_REMOTE_CMD_CTRL)) begin
            remote_cmd_ctrl <= (wr_byte & orcc_pkg::CMD_CTRL_RW_MASK)
                             | (orcc_pkg::RST_REMOTE_CMD_CTRL & ~orcc_pkg::CMD_CTRL_RW_MASK);
        end
    end

    // remote command address and data bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remote_cmd_address_byte <= orcc_pkg::RST_BYTE_ZERO;
            remote_cmd_data_byte <= orcc_pkg::RST_BYTE_ZERO;
        end else if (wr_lane_ok) begin
            if (reg_hit(wr_addr, orcc_pkg::IDX_REMOTE_CMD_ADDRESS_BYTE)) begin
                remote_cmd_address_byte <= wr_byte;
            end
            if (reg_hit(wr_addr, orcc_pkg::IDX_REMOTE_CMD_DATA_BYTE)) begin
                remote_cmd_data_byte <= wr_byte;
            end
        end
    end

    // model information bytes used outside remote commands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            model_info_2 <= orcc_pkg::RST_BYTE_ZERO;
            model_info_3 <= orcc_pkg::RST_BYTE_ZERO;
        end else if (wr_lane_ok) begin
            if (reg_hit(wr_addr, orcc_pkg::IDX_MODEL_INFO_2)) begin
                model_info_2 <= wr_byte;
            end
            if (reg_hit(wr_addr, orcc_pkg::IDX_MODEL_INFO_3)) begin
                model_info_3 <= wr_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // maintenance packet counters
    // ------------------------------------------------------------

    // a zero written to the control word clears both counts
    assign clear_counts = wr_lane_ok && reg_hit(wr_addr, orcc_pkg::IDX_MAINT_CTRL)
                       && (wr_byte == orcc_pkg::RST_BYTE_ZERO);
    assign rx_valid_packet = maint_rx_done && rx_crc_ok && rx_opcode_ok
                          && rx_direction_ok;

    // transmit count; a packet in the clearing cycle still counts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            maint_tx_packet_count <= orcc_pkg::RST_BYTE_ZERO;
        end else if (maint_tx_sent) begin
            if (clear_counts) begin
                maint_tx_packet_count <= orcc_pkg::COUNT_ONE;
            end else begin
                maint_tx_packet_count <= sat_inc(maint_tx_packet_count);
            end
        end else if (clear_counts) begin
            maint_tx_packet_count <= orcc_pkg::RST_BYTE_ZERO;
        end
    end

    // receive count of packets that pass every check
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            maint_rx_packet_count <= orcc_pkg::RST_BYTE_ZERO;
        end else if (rx_valid_packet) begin
            if (clear_counts) begin
                maint_rx_packet_count <= orcc_pkg::COUNT_ONE;
            end else begin
                maint_rx_packet_count <= sat_inc(maint_rx_packet_count);
            end
        end else if (clear_counts) begin
            maint_rx_packet_count <= orcc_pkg::RST_BYTE_ZERO;
        end
    end

    // ------------------------------------------------------------
    // partner status shadow
    // ------------------------------------------------------------

    // shadow reset follows the converter mode reset value
    localparam logic [7:0] RST_SHADOW_FOR_MODE =
        orcc_pkg::RST_CONVERTER_CFG[orcc_pkg::CFG_CENTRAL_BIT]
        ? orcc_pkg::RST_SHADOW_CENTER : orcc_pkg::RST_SHADOW_TERMINAL;

    // center mode freezes the copy from a warm reset or power down
    // until the cycle after the first cycle the link is up again outside those events
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shadow_hold <= 1'b0;
        end else if (!central_mode) begin
            shadow_hold <= 1'b0;
        end else if (warm_reset || chip_power_down) begin
            shadow_hold <= 1'b1;
        end else if (optical_link_up) begin
            shadow_hold <= 1'b0;
        end
    end

    // the copy keeps the partner status bit layout unchanged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            partner_status_shadow <= RST_SHADOW_FOR_MODE;
        end else if (!central_mode) begin
            if (optical_link_up) begin
                partner_status_shadow <= partner_status;
            end
        end else if (optical_link_up && !shadow_hold && !warm_reset && !chip_power_down) begin
            partner_status_shadow <= partner_status;
        end
    end

    // ------------------------------------------------------------
    // frame field sourcing
    // ------------------------------------------------------------

    // only a center side command in extended mode takes the command bytes
    assign use_remote_cmd = remote_cmd_issue && central_mode && extended_mode;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_field_byte4 <= orcc_pkg::RST_BYTE_ZERO;
            frame_field_byte5 <= orcc_pkg::RST_BYTE_ZERO;
        end else if (use_remote_cmd) begin
            frame_field_byte4 <= remote_cmd_address_byte;
            frame_field_byte5 <= remote_cmd_data_byte;
        end else begin
            frame_field_byte4 <= model_info_2;
            frame_field_byte5 <= model_info_3;
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------

    // read multiplexer over the register words
    always_comb begin
        rd_hit = 1'b1;
        rd_byte = orcc_pkg::RST_BYTE_ZERO;
        if (reg_hit(s_axi_araddr, orcc_pkg::IDX_MAINT_CTRL)) begin
            rd_byte = maint_ctrl;
        end else if (reg_hit(s_axi_araddr, orcc_pkg::IDX_REMOTE_CMD_CTRL)) begin
            rd_byte = remote_cmd_ctrl;
        end else if (reg_hit(s_axi_araddr, orcc_pkg::IDX_REMOTE_CMD_ADDRESS_BYTE)) begin
            rd_byte = remote_cmd_address_byte;
        end else if (reg_hit(s_axi_araddr, orcc_pkg::IDX_REMOTE_CMD_DATA_BYTE)) begin
            rd_byte = remote_cmd_data_byte;
        end else if (reg_hit(s_axi_araddr, orcc_pkg::IDX_MAINT_TX_PACKET_COUNT)) begin
            rd_byte = maint_tx_packet_count;
        end else if (reg_hit(s_axi_araddr, orcc_pkg::IDX_MAINT_RX_PACKET_COUNT)) begin
            rd_byte = maint_rx_packet_count;
        end else if (reg_hit(s_axi_araddr, orcc_pkg::IDX_PARTNER_STATUS_SHADOW)) begin
            rd_byte = partner_status_shadow;
        end else if (reg_hit(s_axi_araddr, orcc_pkg::IDX_MODEL_INFO_2)) begin
            rd_byte = model_info_2;
        end else if (reg_hit(s_axi_araddr, orcc_pkg::IDX_MODEL_INFO_3)) begin
            rd_byte = model_info_3;
        end else if (reg_hit(s_axi_araddr, orcc_pkg::IDX_CONVERTER_CFG)) begin
            rd_byte = converter_cfg;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // one read at a time; ready is a single-cycle pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else if (s_axi_arready) begin
            s_axi_arready <= 1'b0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // data captured on the address handshake, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= orcc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? orcc_pkg::RESP_OKAY : orcc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: bench/orcc_peer_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// peer converter on the far side of the optical link
// ------------------------------------------------------------
module orcc_peer_model (
    // clock
    input wire logic aclk,
    // bench control
    input wire logic want_link,
    input wire logic [7:0] want_status,
    input wire logic send_rx,
    input wire logic [2:0] rx_ok,
    // link side seen by the block
    output logic optical_link_up,
    output logic [7:0] partner_status,
    output logic maint_rx_done,
    output logic rx_crc_ok,
    output logic rx_opcode_ok,
    output logic rx_direction_ok
);
    // a released status line shows the inverse of its last value
    always_ff @(posedge aclk) begin
        optical_link_up <= want_link;
        partner_status <= want_link ? want_status : ~partner_status;
    end

    // receive pulse; check flags wander between packets
    always_ff @(posedge aclk) begin
        maint_rx_done <= send_rx;
        if (send_rx) begin
            {rx_crc_ok, rx_opcode_ok, rx_direction_ok} <= rx_ok;
        end else begin
            {rx_crc_ok, rx_opcode_ok, rx_direction_ok} <= ~{rx_crc_ok, rx_opcode_ok, rx_direction_ok};
        end
    end
endmodule

`default_nettype wire

// file: bench/orcc_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// port checker for the register block
// ------------------------------------------------------------
module orcc_regs_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // frame bytes
    input wire logic [7:0] frame_field_byte4,
    input wire logic [7:0] frame_field_byte5
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready longer than one cycle");
    wr_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read answer late or wide");
    r_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped");
    rst_frame_a: assert property (
        !$past(aresetn) |-> frame_field_byte4 == 8'h00 && frame_field_byte5 == 8'h00)
        else $error("frame bytes not cleared by reset");
    resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
        else $error("illegal write response code");

    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'b10);
    cover property (frame_field_byte4 != 8'h00);
endmodule

bind orcc_regs orcc_regs_checker i_orcc_regs_checker (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .frame_field_byte4, .frame_field_byte5);

`default_nettype wire

// file: bench/tb_oam_remote_cmd_counters.sv
`timescale 1ns/100ps
`default_nettype none

module tb_oam_remote_cmd_counters;
    // ------------------------------------------------------------
    // bench signals
    // ------------------------------------------------------------
    logic aclk = 0;
    logic aresetn = 0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, maint_tx_sent = 0, remote_cmd_issue = 0, warm_reset = 0;
    logic chip_power_down = 0, want_link = 0, send_rx = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic optical_link_up, maint_rx_done, rx_crc_ok, rx_opcode_ok, rx_direction_ok;
    logic [7:0] want_status = 8'h00, partner_status, frame_field_byte4, frame_field_byte5;
    logic [2:0] rx_ok = 3'h0;
    int err_count = 0;
    int checks_done = 0;

    // 125 MHz clock
    always #4 aclk = ~aclk;

    orcc_regs i_orcc_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .optical_link_up, .partner_status, .warm_reset, .chip_power_down, .maint_tx_sent,
        .maint_rx_done, .rx_crc_ok, .rx_opcode_ok, .rx_direction_ok, .remote_cmd_issue,
        .frame_field_byte4, .frame_field_byte5);

    orcc_peer_model i_orcc_peer_model (.aclk, .want_link, .want_status, .send_rx, .rx_ok,
        .optical_link_up, .partner_status, .maint_rx_done, .rx_crc_ok, .rx_opcode_ok,
        .rx_direction_ok);

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_awvalid || s_axi_wvalid);
        s_axi_bready <= 1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
        chk(s_axi_rdata, {24'h0, e});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_access;
        for (int i = 0; i < 4; i++) rd(8'h4b + 8'(i), 8'h00, 2'b00);
        rd(8'h4f, 8'h07, 2'b00);
        rd(8'h10, 8'h00, 2'b10);
        wr(8'h4b, 8'ha5, 2'b00);
        wr(8'h4c, 8'h5a, 2'b00);
        wr(8'h4d, 8'hff, 2'b00);
        rd(8'h4b, 8'ha5, 2'b00);
        rd(8'h4c, 8'h5a, 2'b00);
        rd(8'h4d, 8'h00, 2'b00);
    endtask

    task automatic t_counters;
        @(posedge aclk) maint_tx_sent <= 1;
        cyc(3);
        maint_tx_sent <= 0;
        for (int f = 0; f < 8; f++) begin
            @(posedge aclk) {send_rx, rx_ok} <= {1'b1, 3'(f)};
            @(posedge aclk) send_rx <= 0;
        end
        rd(8'h4d, 8'h03, 2'b00);
        rd(8'h4e, 8'h01, 2'b00);
        wr(8'h44, 8'h01, 2'b00);
        rd(8'h4d, 8'h03, 2'b00);
        wr(8'h44, 8'h00, 2'b00);
        rd(8'h4d, 8'h00, 2'b00);
        rd(8'h4e, 8'h00, 2'b00);
        @(posedge aclk) maint_tx_sent <= 1;
        cyc(300);
        maint_tx_sent <= 0;
        rd(8'h4d, 8'hff, 2'b00);
    endtask

    task automatic t_frame;
        wr(8'h56, 8'h11, 2'b00);
        wr(8'h57, 8'h22, 2'b00);
        wr(8'h60, 8'h01, 2'b00);
        wr(8'h4a, 8'h02, 2'b00);
        rd(8'h4a, 8'h22, 2'b00);
        remote_cmd_issue <= 1;
        cyc(3);
        chk({24'h0, frame_field_byte4}, 32'h0000_00a5);
        chk({24'h0, frame_field_byte5}, 32'h0000_005a);
        wr(8'h60, 8'h00, 2'b00);
        cyc(2);
        chk({24'h0, frame_field_byte4}, 32'h0000_0011);
        wr(8'h60, 8'h01, 2'b00);
        wr(8'h4a, 8'h00, 2'b00);
        cyc(2);
        chk({24'h0, frame_field_byte4}, 32'h0000_0011);
        chk({24'h0, frame_field_byte5}, 32'h0000_0022);
        remote_cmd_issue <= 0;
    endtask

    task automatic t_shadow;
        wr(8'h60, 8'h00, 2'b00);
        @(posedge aclk) {want_link, want_status} <= {1'b1, 8'h3c};
        rd(8'h4f, 8'h3c, 2'b00);
        @(posedge aclk) {want_link, want_status} <= {1'b0, 8'hc3};
        rd(8'h4f, 8'h3c, 2'b00);
        wr(8'h60, 8'h01, 2'b00);
        @(posedge aclk) {want_link, want_status} <= {1'b1, 8'h55};
        rd(8'h4f, 8'h55, 2'b00);
        for (int ev = 0; ev < 2; ev++) begin
            @(posedge aclk) {warm_reset, chip_power_down, want_status} <= {ev == 0, ev == 1, 8'h66};
            rd(8'h4f, 8'h55, 2'b00);
            @(posedge aclk) want_link <= 0;
            cyc(2);
            {warm_reset, chip_power_down} <= 2'b00;
            rd(8'h4f, 8'h55, 2'b00);
            @(posedge aclk) {want_link, want_status} <= {1'b1, 8'h66};
            cyc(1);
            rd(8'h4f, 8'h66, 2'b00);
            @(posedge aclk) want_status <= 8'h55;
            rd(8'h4f, 8'h55, 2'b00);
        end
    endtask

    task automatic final_report;
        if (err_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // main sequence after two cycles of reset
    initial begin
        cyc(2);
        aresetn <= 1;
        t_access;
        t_counters;
        t_frame;
        t_shadow;
        final_report;
    end

    // watchdog against a hung handshake
    initial begin
        cyc(20000);
        err_count++;
        final_report;
    end
endmodule

`default_nettype wire
